// ===== verification/mac_tx_rx_control_registers_tb.sv
// self-checking testbench for the transmit and receive control register bank
`timescale 1ns/1ps
module mac_tx_rx_control_registers_tb;
	import mtrc_pkg::*;

	// ----------------------------------------------------------------
	// signals and design instance
	// ----------------------------------------------------------------
	localparam logic [65:0] PCS_D = 66'h2_0123_4567_89AB_CDEF;
	localparam logic [65:0] AN_D  = 66'h1_FEDC_BA98_7654_3210;
	localparam logic [65:0] TR_D  = 66'h3_A5A5_5A5A_0F0F_F0F0;

	logic        sys_clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [5:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [65:0] pmaTxData;
	logic [65:0] txPcsData;
	logic [65:0] txAutoNegData;
	logic [65:0] txTrainData;
	logic        blockLockPin;
	logic        highBerPin;
	logic [5:0]  perPktIfg;
	logic        frameStart;
	logic        frameEnd;
	logic [5:0]  gapCount;
	logic        dicEnable;
	logic        leadInEnable;
	logic [2:0]  leadInWordsMinusOne;
	logic [47:0] pauseSrcAddr;
	logic [3:0]  txFifoAfThreshold;
	logic        txEnableLive;
	int          badCount;
	int          checks;
	logic [5:0]  ifgV [6];
	logic [5:0]  gapE [6];

	mtrc_regs #(
		.BUILD_KR                 (1'b1),
		.BUILD_TX_LPBK            (1'b1),
		.BUILD_CUSTOM_LEAD_IN     (1'b1),
		.BUILD_LEAD_IN_WORD_COUNT (3'h5),
		.BUILD_NEW_PAUSE          (1'b1)
	) mtrc_regs_inst (
		.sys_clk             (sys_clk),
		.rst_n               (rst_n),
		.psel                (psel),
		.penable             (penable),
		.pwrite              (pwrite),
		.paddr               (paddr),
		.pwdata              (pwdata),
		.prdata              (prdata),
		.pready              (pready),
		.pslverr             (pslverr),
		.txPcsData           (txPcsData),
		.txAutoNegData       (txAutoNegData),
		.txTrainData         (txTrainData),
		.pmaTxData           (pmaTxData),
		.blockLockPin        (blockLockPin),
		.highBerPin          (highBerPin),
		.perPktIfg           (perPktIfg),
		.frameStart          (frameStart),
		.frameEnd            (frameEnd),
		.gapCount            (gapCount),
		.dicEnable           (dicEnable),
		.leadInEnable        (leadInEnable),
		.leadInWordsMinusOne (leadInWordsMinusOne),
		.pauseSrcAddr        (pauseSrcAddr),
		.txFifoAfThreshold   (txFifoAfThreshold),
		.txEnableLive        (txEnableLive)
	);

	always #4 sys_clk = ~sys_clk;

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [65:0] seen, input logic [65:0] exp);
		checks++;
		if (seen !== exp) begin
			badCount++;
			$display("unexpected at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [5:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 8);
		// a transfer that never completes counts as a mismatch
		if (pready !== 1'b1) badCount++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, d, rd, err);
	endtask

	task automatic rdck(input logic [5:0] a, input logic [31:0] exp,
		input logic eerr);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 32'h0, rd, err);
		check({34'h0, rd}, {34'h0, exp});
		check({65'h0, err}, {65'h0, eerr});
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic pulse(input logic isEnd);
		@(posedge sys_clk);
		if (isEnd) frameEnd <= 1'b1;
		else frameStart <= 1'b1;
		@(posedge sys_clk);
		frameEnd <= 1'b0;
		frameStart <= 1'b0;
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", checks, badCount);
		if (badCount == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (5000) @(posedge sys_clk);
		badCount++;
		test_done;
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		rst_n = 1'b0;
		{psel, penable, pwrite, frameStart, frameEnd} = 5'h00;
		paddr = 6'h00;
		pwdata = 32'h0;
		{blockLockPin, highBerPin} = 2'h0;
		perPktIfg = 6'h05;
		txPcsData = PCS_D;
		txAutoNegData = AN_D;
		txTrainData = TR_D;
		badCount = 0;
		checks = 0;
		ifgV = '{6'h00, 6'h01, 6'h0C, 6'h30, 6'h31, 6'h3F};
		gapE = '{6'h01, 6'h01, 6'h0C, 6'h30, 6'h30, 6'h30};
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		settle(1);
		check(66'(gapCount), 66'h0C);
		check(66'({dicEnable, leadInEnable, txEnableLive}), 66'h5);
		check(66'(leadInWordsMinusOne), 66'h5);
		check(66'({pauseSrcAddr, txFifoAfThreshold}), 66'h0);
		rdck(6'h00, 32'h0, 1'b0);
		rdck(6'h04, 32'h9, 1'b0);
		rdck(6'h14, 32'h1, 1'b0);
		rdck(6'h20, 32'h0C15, 1'b0);
		rdck(6'h24, 32'h0, 1'b0);
		rdck(6'h28, 32'h0, 1'b0);
		rdck(6'h2C, 32'h0001_0000, 1'b0);
		rdck(6'h10, 32'h0, 1'b0);
		$display("test reset values finished");

		for (int v = 0; v < 4; v++) begin
			wr(6'h00, 32'(v));
			rdck(6'h00, 32'(v), 1'b0);
			settle(3);
			check(pmaTxData, (v == 0) ? PCS_D : (v == 2) ? AN_D :
				(v == 3) ? TR_D : 66'h0);
		end
		wr(6'h00, 32'hFFFF_FFFF);
		rdck(6'h00, 32'h3, 1'b0);
		wr(6'h04, 32'hFFFF_FFFF);
		rdck(6'h04, 32'h9, 1'b0);
		rdck(6'h08, 32'h0, 1'b1);
		rdck(6'h30, 32'h0, 1'b1);
		$display("test source select finished");

		for (int i = 0; i < 6; i++) begin
			wr(6'h20, {18'h0, ifgV[i], 3'h0, 1'(i), 1'b1, 3'h2});
			rdck(6'h20, {18'h0, ifgV[i], 3'h0, 1'(i), 1'b1, 3'h2},
				1'b0);
			settle(3);
			check(66'(gapCount), 66'(gapE[i]));
			check(66'({dicEnable, leadInEnable}),
				66'({1'(i), 1'b1}));
			check(66'(leadInWordsMinusOne), 66'h2);
		end
		wr(6'h20, 32'hFFFF_FFFF);
		rdck(6'h20, 32'h3F1F, 1'b0);
		$display("test gap and lead-in finished");

		wr(6'h24, 32'hDEAD_BEEF);
		wr(6'h28, 32'hFFFF_A5C3);
		rdck(6'h28, 32'hA5C3, 1'b0);
		settle(3);
		check(66'(pauseSrcAddr), 66'hA5C3_DEAD_BEEF);
		wr(6'h2C, 32'hFFFF_FFFF);
		rdck(6'h2C, 32'h001F_0000, 1'b0);
		settle(3);
		check(66'(txFifoAfThreshold), 66'hF);
		$display("test pause and threshold finished");

		pulse(1'b0);
		wr(6'h2C, 32'h0);
		settle(4);
		check(66'(txEnableLive), 66'h1);
		pulse(1'b1);
		settle(3);
		check(66'(txEnableLive), 66'h0);
		// a start while disabled must not open a frame
		pulse(1'b0);
		wr(6'h2C, 32'h0001_0000);
		settle(4);
		check(66'(txEnableLive), 66'h1);
		$display("test transmit enable finished");

		@(posedge sys_clk);
		blockLockPin <= 1'b1;
		settle(5);
		rdck(6'h10, 32'h1, 1'b0);
		highBerPin <= 1'b1;
		settle(5);
		rdck(6'h10, 32'h0, 1'b0);
		highBerPin <= 1'b0;
		blockLockPin <= 1'b0;
		settle(5);
		rdck(6'h10, 32'h0, 1'b0);
		$display("test lock status finished");
		test_done;
	end
endmodule

// ===== verilog/mtrc_gap_cfg.sv
// effective inter-frame gap and deficit idle settings
`timescale 1ns/1ps
module mtrc_gap_cfg #(
	parameter int PER_PKT_IFG = 0
) (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic [5:0] staticIfg,
	input  wire logic       staticDic,
	input  wire logic [5:0] perPktIfg,
	output logic      [5:0] gapCount,
	output logic            dicEnable
);
	import mtrc_pkg::*;

	logic [5:0] gapCount_q, gapCount_d;
	logic       dicEnable_q, dicEnable_d;

	function automatic logic [5:0] clampGap(input logic [5:0] v);
		if (v < IFG_MIN) return IFG_MIN;
		if (v > IFG_MAX) return IFG_MAX;
		return v;
	endfunction

	always_comb begin
		if (PER_PKT_IFG == 0) begin
			gapCount_d  = clampGap(staticIfg); // R07 R08 R09
			dicEnable_d = staticDic; // R10
		end else begin
			gapCount_d  = clampGap(perPktIfg); // R09
			dicEnable_d = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gapCount_q  <= IFG_RST;
			dicEnable_q <= DIC_RST;
		end else begin
			gapCount_q  <= gapCount_d;
			dicEnable_q <= dicEnable_d;
		end
	end

	assign gapCount  = gapCount_q;
	assign dicEnable = dicEnable_q;

	chk_gap_in_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
		gapCount_q >= IFG_MIN && gapCount_q <= IFG_MAX) // R08
		else $error("gap count outside 1..48");
	chk_gap_follows_cfg: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(PER_PKT_IFG == 0 && staticIfg >= IFG_MIN && staticIfg <= IFG_MAX)
		|=> gapCount_q == $past(staticIfg)) // R07
		else $error("gap count does not follow static setting");
	chk_dic_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
		##1 dicEnable_q == (PER_PKT_IFG == 0 && $past(staticDic))) // R10
		else $error("deficit idle enable wrong");
endmodule

// ===== verilog/mtrc_pkg.sv
// constants for the MAC transmit and receive control registers
//
// Behaviour
// R01 - Source select bits [1:0] reset to 0 and route 0 to 10G PCS, 2 to auto-negotiation and 3 to link training.
// R02 - Source select value 1 (1G PCS) is unsupported and software must not rely on it.
// R03 - Transmit build readback bit 3 is read-only and returns the build transmit local loopback setting.
// R04 - Bit 0 of both build readback registers returns the line variant, 0 plain serial, 1 backplane.
// R05 - Receive status bit 0 is read-only and is high only while block lock holds without high error rate.
// R06 - Receive build readback bit 3 is read-only and returns the build receive local loopback setting.
// R07 - Static gap count bits [13:8] reset to 12 and set the gap between transmitted frames.
// R08 - A programmed gap below 1 acts as 1 and one above 48 acts as 48.
// R09 - Static gap and deficit idle settings apply only when the per-packet gap build value is 0.
// R10 - Bit 4 resets to 1 and turns deficit idle gap averaging on when high, off when low.
// R11 - Static bit 3 resets to 0 and enables the user lead-in only when the custom lead-in build option is 1.
// R12 - Bits [2:0] give lead-in length as words minus one and reset to the build word count value.
// R13 - A 48-bit pause source address in a low and a high word, both reset to 0, is used when new-pause is built in.
// R14 - Bits [20:17] reset to 0, set the transmit FIFO almost-full threshold and may change during traffic.
// R15 - Bit 16 resets to 1 and allows frame transmission while high; while low no data frames are sent.
// R16 - Transmit enable is sampled only at packet boundaries so no frame is ever cut short.
// R17 - Reserved bits read as zero and ignore writes.
package mtrc_pkg;
	// address layout: paddr[5:4] group, paddr[3:2] register index
	localparam int          ADDR_W      = 6;
	localparam logic [1:0]  GRP_TX_CTRL = 2'h0;
	localparam logic [1:0]  GRP_RX_CTRL = 2'h1;
	localparam logic [1:0]  GRP_MAC_TX  = 2'h2;
	localparam logic [1:0]  IDX_SRC_SEL = 2'h0;
	localparam logic [1:0]  IDX_TX_BLD  = 2'h1;
	localparam logic [1:0]  IDX_RX_STAT = 2'h0;
	localparam logic [1:0]  IDX_RX_BLD  = 2'h1;
	localparam logic [1:0]  IDX_STATIC  = 2'h0;
	localparam logic [1:0]  IDX_PAUSE_LO = 2'h1;
	localparam logic [1:0]  IDX_PAUSE_HI = 2'h2;
	localparam logic [1:0]  IDX_RUN_CFG = 2'h3;

	// line source encodings
	localparam logic [1:0]  SRC_PCS10G  = 2'h0;
	localparam logic [1:0]  SRC_PCS1G   = 2'h1;
	localparam logic [1:0]  SRC_AUTONEG = 2'h2;
	localparam logic [1:0]  SRC_TRAIN   = 2'h3;

	// field positions
	localparam int          BLD_LPBK_BIT   = 3;
	localparam int          BLD_KR_BIT     = 0;
	localparam int          STAT_LOCK_BIT  = 0;
	localparam int          IFG_LSB        = 8;
	localparam int          IFG_MSB        = 13;
	localparam int          DIC_BIT        = 4;
	localparam int          LEADIN_EN_BIT  = 3;
	localparam int          WCM1_MSB       = 2;
	localparam int          PAF_LSB        = 17;
	localparam int          PAF_MSB        = 20;
	localparam int          TX_EN_BIT      = 16;
	localparam int          ADDR_HI_MSB    = 15;

	// reset values
	localparam logic [1:0]  SRC_RST       = 2'h0;
	localparam logic [5:0]  IFG_RST       = 6'h0C;
	localparam logic        DIC_RST       = 1'b1;
	localparam logic        LEADIN_EN_RST = 1'b0;
	localparam logic [3:0]  PAF_RST       = 4'h0;
	localparam logic        TX_EN_RST     = 1'b1;

	// gap clamp limits
	localparam logic [5:0]  IFG_MIN = 6'h01;
	localparam logic [5:0]  IFG_MAX = 6'h30;
endpackage

// ===== verilog/mtrc_regs.sv
// MAC transmit and receive control register bank on the APB port
`timescale 1ns/1ps
module mtrc_regs #(
	parameter int         DATA_W          = 66,
	parameter bit         BUILD_KR        = 1'b0,
	parameter bit         BUILD_TX_LPBK   = 1'b0,
	parameter bit         BUILD_RX_LPBK   = 1'b0,
	parameter int         PER_PKT_IFG     = 0,
	parameter bit         BUILD_CUSTOM_LEAD_IN = 1'b0,
	parameter logic [2:0] BUILD_LEAD_IN_WORD_COUNT = 3'h1,
	parameter bit         BUILD_NEW_PAUSE = 1'b0
) (
	input  wire logic                      sys_clk,
	input  wire logic                      rst_n,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [mtrc_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic [DATA_W-1:0]         txPcsData,
	input  wire logic [DATA_W-1:0]         txAutoNegData,
	input  wire logic [DATA_W-1:0]         txTrainData,
	output logic      [DATA_W-1:0]         pmaTxData,
	input  wire logic                      blockLockPin,
	input  wire logic                      highBerPin,
	input  wire logic [5:0]                perPktIfg,
	input  wire logic                      frameStart,
	input  wire logic                      frameEnd,
	output logic      [5:0]                gapCount,
	output logic                           dicEnable,
	output logic                           leadInEnable,
	output logic      [2:0]                leadInWordsMinusOne,
	output logic      [47:0]               pauseSrcAddr,
	output logic      [3:0]                txFifoAfThreshold,
	output logic                           txEnableLive
);
	import mtrc_pkg::*;

	if (DATA_W < 1) begin : g_bad_width
		$error("DATA_W must be at least 1");
	end
	if (PER_PKT_IFG < 0) begin : g_bad_ifg
		$error("PER_PKT_IFG must not be negative");
	end

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic logic hitReg(input logic [ADDR_W-1:0] a,
		input logic [1:0] grp, input logic [1:0] idx);
		return a[5:4] == grp && a[3:2] == idx;
	endfunction

	logic setupPh, writePh;
	assign setupPh = psel && !penable;
	assign writePh = psel && penable && pwrite;

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	logic [1:0]  srcSel_q, srcSel_d;
	logic [5:0]  ifg_q, ifg_d;
	logic        dic_q, dic_d;
	logic        leadEn_q, leadEn_d;
	logic [2:0]  wcm1_q, wcm1_d;
	logic [31:0] addrLo_q, addrLo_d;
	logic [15:0] addrHi_q, addrHi_d;
	logic [3:0]  paf_q, paf_d;
	logic        txEn_q, txEn_d;

	always_comb begin
		srcSel_d = srcSel_q;
		ifg_d    = ifg_q;
		dic_d    = dic_q;
		leadEn_d = leadEn_q;
		wcm1_d   = wcm1_q;
		addrLo_d = addrLo_q;
		addrHi_d = addrHi_q;
		paf_d    = paf_q;
		txEn_d   = txEn_q;
		if (writePh) begin
			// only defined fields are stored; other bits are dropped
			if (hitReg(paddr, GRP_TX_CTRL, IDX_SRC_SEL))
				srcSel_d = pwdata[1:0]; // R01 R17
			if (hitReg(paddr, GRP_MAC_TX, IDX_STATIC)) begin
				ifg_d    = pwdata[IFG_MSB:IFG_LSB]; // R07
				dic_d    = pwdata[DIC_BIT]; // R10
				leadEn_d = pwdata[LEADIN_EN_BIT]; // R11
				wcm1_d   = pwdata[WCM1_MSB:0]; // R12
			end
			if (hitReg(paddr, GRP_MAC_TX, IDX_PAUSE_LO))
				addrLo_d = pwdata; // R13
			if (hitReg(paddr, GRP_MAC_TX, IDX_PAUSE_HI))
				addrHi_d = pwdata[ADDR_HI_MSB:0]; // R13
			if (hitReg(paddr, GRP_MAC_TX, IDX_RUN_CFG)) begin
				paf_d  = pwdata[PAF_MSB:PAF_LSB]; // R14
				txEn_d = pwdata[TX_EN_BIT]; // R15
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			srcSel_q <= SRC_RST; // R01
			ifg_q    <= IFG_RST; // R07
			dic_q    <= DIC_RST; // R10
			leadEn_q <= LEADIN_EN_RST; // R11
			wcm1_q   <= BUILD_LEAD_IN_WORD_COUNT; // R12
			addrLo_q <= 32'h00000000; // R13
			addrHi_q <= 16'h0000; // R13
			paf_q    <= PAF_RST; // R14
			txEn_q   <= TX_EN_RST; // R15
		end else begin
			srcSel_q <= srcSel_d;
			ifg_q    <= ifg_d;
			dic_q    <= dic_d;
			leadEn_q <= leadEn_d;
			wcm1_q   <= wcm1_d;
			addrLo_q <= addrLo_d;
			addrHi_q <= addrHi_d;
			paf_q    <= paf_d;
			txEn_q   <= txEn_d;
		end
	end

	// ----------------------------------------------------------------
	// receive lock status
	// ----------------------------------------------------------------
	logic lockS1_q, lockS2_q, berS1_q, berS2_q, lockOk_q, lockOk_d;

	assign lockOk_d = lockS2_q && !berS2_q; // R05

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lockS1_q <= 1'b0;
			lockS2_q <= 1'b0;
			berS1_q  <= 1'b0;
			berS2_q  <= 1'b0;
			lockOk_q <= 1'b0;
		end else begin
			lockS1_q <= blockLockPin;
			lockS2_q <= lockS1_q;
			berS1_q  <= highBerPin;
			berS2_q  <= berS1_q;
			lockOk_q <= lockOk_d;
		end
	end

	// ----------------------------------------------------------------
	// read path, error and ready
	// ----------------------------------------------------------------
	logic [31:0] rdata_q, rdata_d;
	logic        err_q, err_d;
	logic        ready_q;
	logic [31:0] rdMux;
	logic        mapped;

	always_comb begin
		rdMux  = 32'h00000000; // R17
		mapped = 1'b1;
		if (hitReg(paddr, GRP_TX_CTRL, IDX_SRC_SEL))
			rdMux[1:0] = srcSel_q;
		else if (hitReg(paddr, GRP_TX_CTRL, IDX_TX_BLD)) begin
			rdMux[BLD_LPBK_BIT] = BUILD_TX_LPBK; // R03
			rdMux[BLD_KR_BIT]   = BUILD_KR; // R04
		end else if (hitReg(paddr, GRP_RX_CTRL, IDX_RX_STAT))
			rdMux[STAT_LOCK_BIT] = lockOk_q; // R05
		else if (hitReg(paddr, GRP_RX_CTRL, IDX_RX_BLD)) begin
			rdMux[BLD_LPBK_BIT] = BUILD_RX_LPBK; // R06
			rdMux[BLD_KR_BIT]   = BUILD_KR; // R04
		end else if (hitReg(paddr, GRP_MAC_TX, IDX_STATIC)) begin
			rdMux[IFG_MSB:IFG_LSB] = ifg_q;
			rdMux[DIC_BIT]         = dic_q;
			rdMux[LEADIN_EN_BIT]   = leadEn_q;
			rdMux[WCM1_MSB:0]      = wcm1_q;
		end else if (hitReg(paddr, GRP_MAC_TX, IDX_PAUSE_LO))
			rdMux = addrLo_q;
		else if (hitReg(paddr, GRP_MAC_TX, IDX_PAUSE_HI))
			rdMux[ADDR_HI_MSB:0] = addrHi_q;
		else if (hitReg(paddr, GRP_MAC_TX, IDX_RUN_CFG)) begin
			rdMux[PAF_MSB:PAF_LSB] = paf_q;
			rdMux[TX_EN_BIT]       = txEn_q;
		end else
			mapped = 1'b0;
		rdata_d = rdata_q;
		err_d   = err_q;
		if (setupPh) begin
			rdata_d = pwrite ? 32'h00000000 : rdMux;
			err_d   = !mapped;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 32'h00000000;
			err_q   <= 1'b0;
			ready_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			err_q   <= err_d;
			ready_q <= 1'b1;
		end
	end

	assign prdata  = rdata_q;
	assign pslverr = err_q;
	assign pready  = ready_q;

	// ----------------------------------------------------------------
	// datapath facing fields
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] pma_q, pma_d;
	logic              leadOut_q, leadOut_d;
	logic [2:0]        wcmOut_q;
	logic [47:0]       pause_q, pause_d;
	logic [3:0]        pafOut_q;

	always_comb begin
		case (srcSel_q)
			SRC_PCS10G:  pma_d = txPcsData; // R01
			SRC_AUTONEG: pma_d = txAutoNegData; // R01
			SRC_TRAIN:   pma_d = txTrainData; // R01
			SRC_PCS1G:   pma_d = '0; // R02
			default:     pma_d = '0;
		endcase
		leadOut_d = BUILD_CUSTOM_LEAD_IN && leadEn_q; // R11
		pause_d   = BUILD_NEW_PAUSE ? {addrHi_q, addrLo_q} : 48'h0; // R13
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pma_q     <= '0;
			leadOut_q <= 1'b0;
			wcmOut_q  <= 3'h0;
			pause_q   <= 48'h0;
			pafOut_q  <= PAF_RST;
		end else begin
			pma_q     <= pma_d;
			leadOut_q <= leadOut_d;
			wcmOut_q  <= wcm1_q; // R12
			pause_q   <= pause_d;
			pafOut_q  <= paf_q; // R14
		end
	end

	assign pmaTxData           = pma_q;
	assign leadInEnable        = leadOut_q;
	assign leadInWordsMinusOne = wcmOut_q;
	assign pauseSrcAddr        = pause_q;
	assign txFifoAfThreshold   = pafOut_q;

	mtrc_gap_cfg #(
		.PER_PKT_IFG (PER_PKT_IFG)
	) u_gap (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.staticIfg (ifg_q),
		.staticDic (dic_q),
		.perPktIfg (perPktIfg),
		.gapCount  (gapCount),
		.dicEnable (dicEnable)
	);

	mtrc_tx_gate u_gate (
		.sys_clk      (sys_clk),
		.rst_n        (rst_n),
		.cfgEnable    (txEn_q),
		.frameStart   (frameStart),
		.frameEnd     (frameEnd),
		.txEnableLive (txEnableLive),
		.inFrame      ()
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence rdSetup(logic [1:0] g, logic [1:0] i);
		psel && !penable && !pwrite && paddr[5:4] == g && paddr[3:2] == i;
	endsequence

	chk_source_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(srcSel_q == SRC_AUTONEG) |=> pmaTxData == $past(txAutoNegData)) // R01
		else $error("auto-negotiation stream not routed");
	chk_unsupported_zero: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		(srcSel_q == SRC_PCS1G) |=> pmaTxData == '0) // R02
		else $error("unsupported source not silenced");
	chk_tx_build_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rdSetup(GRP_TX_CTRL, IDX_TX_BLD) |=> prdata ==
		(32'(BUILD_TX_LPBK) << BLD_LPBK_BIT | 32'(BUILD_KR))) // R03
		else $error("transmit build readback wrong");
	chk_rx_build_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rdSetup(GRP_RX_CTRL, IDX_RX_BLD) |=> prdata ==
		(32'(BUILD_RX_LPBK) << BLD_LPBK_BIT | 32'(BUILD_KR))) // R06
		else $error("receive build readback wrong");
	chk_lock_status: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(blockLockPin && !highBerPin)[*4] |-> lockOk_q) // R05
		else $error("lock status not raised");
	chk_lock_drop: assert property (@(posedge sys_clk) disable iff (!rst_n)
		highBerPin[*4] |-> !lockOk_q) // R05
		else $error("lock status high during high error rate");
	chk_lead_in_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
		##1 leadInEnable == (BUILD_CUSTOM_LEAD_IN && $past(leadEn_q))) // R11
		else $error("lead-in enable not gated by build option");
	chk_pause_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(writePh && hitReg(paddr, GRP_MAC_TX, IDX_PAUSE_HI)) |-> ##2
		pauseSrcAddr[47:32] == (BUILD_NEW_PAUSE ? $past(pwdata[15:0], 2)
		: 16'h0000)) // R13
		else $error("pause address high word not applied");
	chk_threshold_live: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(writePh && hitReg(paddr, GRP_MAC_TX, IDX_RUN_CFG)) |-> ##2
		txFifoAfThreshold == $past(pwdata[PAF_MSB:PAF_LSB], 2)) // R14
		else $error("almost-full threshold not applied");
	chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rdSetup(GRP_MAC_TX, IDX_RUN_CFG) |=> prdata[31:21] == 11'h000
		&& prdata[15:0] == 16'h0000) // R17
		else $error("reserved bits read nonzero");
endmodule

// ===== verilog/mtrc_tx_gate.sv
// transmit enable that only changes between frames
`timescale 1ns/1ps
module mtrc_tx_gate (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic cfgEnable,
	input  wire logic frameStart,
	input  wire logic frameEnd,
	output logic      txEnableLive,
	output logic      inFrame
);
	import mtrc_pkg::*;

	logic live_q, live_d;
	logic inFrame_q, inFrame_d;

	always_comb begin
		// a frame only opens while transmission is allowed
		inFrame_d = inFrame_q;
		if (frameStart && live_q) inFrame_d = 1'b1;
		if (frameEnd) inFrame_d = 1'b0;
		live_d = inFrame_q ? live_q : cfgEnable; // R15 R16
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			live_q    <= TX_EN_RST;
			inFrame_q <= 1'b0;
		end else begin
			live_q    <= live_d;
			inFrame_q <= inFrame_d;
		end
	end

	assign txEnableLive = live_q;
	assign inFrame      = inFrame_q;

	chk_no_mid_change: assert property (@(posedge sys_clk) disable iff (!rst_n)
		inFrame_q |=> $stable(live_q)) // R16
		else $error("transmit enable changed inside a frame");
	chk_idle_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!inFrame_q |=> live_q == $past(cfgEnable)) // R15
		else $error("transmit enable not taken between frames");
	chk_no_start_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!inFrame_q && !live_q) |=> !inFrame_q) // R15
		else $error("frame opened while disabled");
endmodule
